// ===== design/ceob_consts.svh
// constants for the emulated-op and branch executor
`ifndef CEOB_CONSTS_SVH
`define CEOB_CONSTS_SVH

// ----------------------------------------------------------------
// flag_word bit positions
// ----------------------------------------------------------------
`define CEOB_FLAG_C      4'h0
`define CEOB_FLAG_Z      4'h1
`define CEOB_FLAG_N      4'h2
`define CEOB_FLAG_GIE    4'h3
`define CEOB_FLAG_CORE_HALT_BIT 4'h4
`define CEOB_FLAG_OSC_HALT_BIT 4'h5
`define CEOB_FLAG_V      4'h8

// ----------------------------------------------------------------
// constants and reset values
// ----------------------------------------------------------------
`define CEOB_IRQ_MASK    16'h0008
`define CEOB_FLAG_RST    16'h0000
`define CEOB_PC_RST      20'h00000
`define CEOB_PC_STEP     20'h00002
`define CEOB_SRC_ONE     16'h0001
`define CEOB_SRC_TWO     16'h0002
`define CEOB_SRC_ALL     16'hffff

`endif

// ===== design/ceob_pkg.sv
// types shared by the emulated-op and branch executor
package ceob_pkg;

   // operation codes; each op has a code of its own
   typedef enum logic [3:0] {
      op_nop       = 4'h0,
      op_sub_two   = 4'h1,
      op_irq_dis   = 4'h2,
      op_irq_en    = 4'h3,
      op_add_one   = 4'h4,
      op_add_two   = 4'h5,
      op_compl     = 4'h6,
      op_br_carry  = 4'h7,
      op_br_zero   = 4'h8,
      op_br_sge    = 4'h9
   } ceob_op_t;

   // one instruction handed to the executor
   typedef struct packed {
      ceob_op_t    op;
      logic        byte_mode;
      logic [15:0] dst;
      logic [9:0]  offset;
   } ceob_req_t;

   // arithmetic result with its four flags
   typedef struct packed {
      logic [15:0] result;
      logic        n;
      logic        z;
      logic        c;
      logic        v;
   } ceob_alu_t;

endpackage

// ===== design/ceob_alu.sv
// adder/xor core shared by the arithmetic emulated ops
`timescale 1ns/10ps
module ceob_alu (
   // operation
   input  wire ceob_pkg::ceob_op_t  op,
   input  wire logic                byte_mode,
   input  wire logic [15:0]         dst,
   // result
   output      ceob_pkg::ceob_alu_t res
);
`include "ceob_consts.svh"

   logic [15:0] src;
   logic        cin;
   logic        use_xor;
   logic [16:0] sum_w;
   logic [8:0]  sum_b;
   logic [15:0] raw;
   logic        cout;
   logic        msb_d;
   logic        msb_s;
   logic        msb_r;

   // each op is its core op with an implied constant source
   always_comb begin
      src     = 16'h0000;
      cin     = 1'b0;
      use_xor = 1'b0;
      case (op)
         ceob_pkg::op_sub_two: begin
            src = ~`CEOB_SRC_TWO;
            cin = 1'b1;
         end
         ceob_pkg::op_add_one: src = `CEOB_SRC_ONE;
         ceob_pkg::op_add_two: src = `CEOB_SRC_TWO;
         ceob_pkg::op_compl: begin
            src     = `CEOB_SRC_ALL;
            use_xor = 1'b1;
         end
         default: src = 16'h0000;
      endcase
   end

   // byte ops work on the low lane; upper lane of the result is zero
   always_comb begin
      sum_w = {1'b0, dst} + {1'b0, src} + {16'h0000, cin};
      sum_b = {1'b0, dst[7:0]} + {1'b0, src[7:0]} + {8'h00, cin};
      if (use_xor) begin
         raw  = byte_mode ? {8'h00, dst[7:0] ^ src[7:0]} : dst ^ src;
         cout = 1'b0;
      end else begin
         raw  = byte_mode ? {8'h00, sum_b[7:0]} : sum_w[15:0];
         cout = byte_mode ? sum_b[8] : sum_w[16];
      end
      msb_d = byte_mode ? dst[7] : dst[15];
      msb_s = byte_mode ? src[7] : src[15];
      msb_r = byte_mode ? raw[7] : raw[15];
      res.result = raw;
      res.n = msb_r;
      res.z = (raw == 16'h0000);
      // overflow: same-sign operands giving other sign; xor: both negative
      if (use_xor) begin
         res.c = (raw != 16'h0000);
         res.v = msb_d & msb_s;
      end else begin
         res.c = cout;
         res.v = (msb_d == msb_s) & (msb_r != msb_d);
      end
   end

endmodule

// ===== design/ceob_branch.sv
// condition test and target adder for conditional branches
`timescale 1ns/10ps
module ceob_branch (
   // instruction
   input  wire ceob_pkg::ceob_op_t op,
   input  wire logic [9:0]         offset,
   input  wire logic [19:0]        pc_seq,
   // flags under test
   input  wire logic               flag_c,
   input  wire logic               flag_z,
   input  wire logic               flag_n,
   input  wire logic               flag_v,
   // decision
   output      logic               is_branch,
   output      logic               taken,
   output      logic [19:0]        target
);

   // condition per branch kind
   always_comb begin
      is_branch = 1'b1;
      taken     = 1'b0;
      case (op)
         ceob_pkg::op_br_carry: taken = flag_c;
         ceob_pkg::op_br_zero:  taken = flag_z;
         ceob_pkg::op_br_sge:   taken = ~(flag_n ^ flag_v);
         default:               is_branch = 1'b0;
      endcase
   end

   // word offset doubled and sign extended to the 20-bit counter
   assign target = pc_seq + {{9{offset[9]}}, offset, 1'b0};

endmodule

// ===== design/ceob_exec.sv
// executor for emulated arithmetic, irq enable/disable and branches
//
// Contract
// - subtract_two sets zero only if destination held 2; N from sign
// - subtract_two clears carry for start 0 or 1, sets it otherwise
// - subtract_two overflow only for 8001h/8000h, byte 81h/80h
// - irq_disable_op ands flag_word with ~08h, clearing irq enable
// - irq_enable_op ors 08h into flag_word, other bits untouched
// - after irq_enable_op the next instruction runs before any irq
// - add_one sets zero and carry only when destination was all ones
// - add_one sets overflow only for 7FFFh, byte 7Fh
// - add_two sets zero only when destination held FFFEh, byte FEh
// - add_two sets carry for FFFEh/FFFFh, byte FEh/FFh
// - add_two sets overflow for 7FFEh/7FFFh, byte 7Eh/7Fh
// - complement_op inverts destination; N from result sign
// - complement_op carry is not zero; overflow if input was negative
// - taken branch adds doubled sign-extended 10-bit offset to PC
// - branch_on_carry branches when carry is one
// - branch_on_zero branches when zero flag is one
// - branch_signed_ge branches when N xor V is zero
// - branches leave every status flag unchanged
// - arithmetic ops keep irq enable and both halt bits
`timescale 1ns/10ps
module ceob_exec (
   // clock, reset, enable
   input  wire logic                 clk,
   input  wire logic                 nrst,
   input  wire logic                 ce,
   // instruction request
   input  wire logic                 exec_valid,
   input  wire ceob_pkg::ceob_req_t  exec_req,
   // program counter load
   input  wire logic                 pc_load,
   input  wire logic [19:0]          pc_load_val,
   // flag_word load from the datapath
   input  wire logic                 flag_load,
   input  wire logic [15:0]          flag_load_val,
   // interrupt request from the controller
   input  wire logic                 irq_pending,
   // instruction results
   output      logic                 exec_done,
   output      logic                 dst_wr,
   output      logic [15:0]          dst_result,
   output      logic                 branch_taken,
   output      logic                 bad_op,
   // architectural state
   output      logic [15:0]          flag_word,
   output      logic [19:0]          pc,
   output      logic                 global_irq_enable,
   output      logic                 osc_halt_bit,
   output      logic                 core_halt_bit,
   // interrupt acceptance
   output      logic                 irq_take
);
`include "ceob_consts.svh"

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   logic [15:0] flag_ff;
   logic [19:0] pc_ff;
   logic [15:0] result_ff;
   logic        wr_ff;
   logic        done_ff;
   logic        taken_ff;
   logic        bad_ff;
   logic        irq_take_ff;
   logic        shadow_ff;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   logic [15:0] nxt_flag;
   logic [19:0] nxt_pc;
   logic        nxt_wr;
   logic        nxt_bad;
   logic        nxt_shadow;
   logic        nxt_irq_take;

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   ceob_pkg::ceob_op_t  op;
   ceob_pkg::ceob_alu_t alu_res;
   logic                is_arith;
   logic                is_branch;
   logic                br_taken;
   logic [19:0]         br_target;
   logic [19:0]         pc_seq;
   logic                run;
   logic                irq_ok;

   assign op     = exec_req.op;
   assign run    = ce & exec_valid;
   assign pc_seq = pc_ff + `CEOB_PC_STEP;

   // arithmetic ops are the ones that write the destination
   always_comb begin
      case (op)
         ceob_pkg::op_sub_two,
         ceob_pkg::op_add_one,
         ceob_pkg::op_add_two,
         ceob_pkg::op_compl: is_arith = 1'b1;
         default:            is_arith = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // datapath units
   // ----------------------------------------------------------------
   ceob_alu u_alu (
      .op        (op),
      .byte_mode (exec_req.byte_mode),
      .dst       (exec_req.dst),
      .res       (alu_res)
   );

   ceob_branch u_branch (
      .op        (op),
      .offset    (exec_req.offset),
      .pc_seq    (pc_seq),
      .flag_c    (flag_ff[`CEOB_FLAG_C]),
      .flag_z    (flag_ff[`CEOB_FLAG_Z]),
      .flag_n    (flag_ff[`CEOB_FLAG_N]),
      .flag_v    (flag_ff[`CEOB_FLAG_V]),
      .is_branch (is_branch),
      .taken     (br_taken),
      .target    (br_target)
   );

   // ----------------------------------------------------------------
   // flag_word update
   // ----------------------------------------------------------------
   // only the four arithmetic bits are touched by the alu ops, so the
   // enable and halt bits ride through unchanged
   always_comb begin
      nxt_flag = flag_ff;
      if (flag_load) begin
         nxt_flag = flag_load_val;
      end else if (run) begin
         case (op)
            ceob_pkg::op_sub_two,
            ceob_pkg::op_add_one,
            ceob_pkg::op_add_two,
            ceob_pkg::op_compl: begin
               nxt_flag[`CEOB_FLAG_C] = alu_res.c;
               nxt_flag[`CEOB_FLAG_Z] = alu_res.z;
               nxt_flag[`CEOB_FLAG_N] = alu_res.n;
               nxt_flag[`CEOB_FLAG_V] = alu_res.v;
            end
            ceob_pkg::op_irq_dis:
               nxt_flag = flag_ff & ~`CEOB_IRQ_MASK;
            ceob_pkg::op_irq_en:
               nxt_flag = flag_ff | `CEOB_IRQ_MASK;
            default:
               nxt_flag = flag_ff;
         endcase
      end
      // accepting an interrupt drops the enable for the service routine
      if (irq_ok & ~run) begin
         nxt_flag[`CEOB_FLAG_GIE] = 1'b0;
      end
   end

   // flags register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flag_ff <= `CEOB_FLAG_RST;
      end else if (ce) begin
         flag_ff <= nxt_flag;
      end
   end

   // ----------------------------------------------------------------
   // program counter
   // ----------------------------------------------------------------
   always_comb begin
      nxt_pc = pc_ff;
      if (pc_load) begin
         nxt_pc = pc_load_val;
      end else if (run) begin
         nxt_pc = (is_branch & br_taken) ? br_target : pc_seq;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_ff <= `CEOB_PC_RST;
      end else if (ce) begin
         pc_ff <= nxt_pc;
      end
   end

   // ----------------------------------------------------------------
   // destination write-back
   // ----------------------------------------------------------------
   assign nxt_wr = run & is_arith;

   // result holds its value between writes so the datapath may sample late
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         result_ff <= 16'h0000;
         wr_ff     <= 1'b0;
      end else if (ce) begin
         wr_ff <= nxt_wr;
         if (nxt_wr) begin
            result_ff <= alu_res.result;
         end
      end
   end

   // ----------------------------------------------------------------
   // completion, branch and decode-error pulses
   // ----------------------------------------------------------------
   // an out-of-range code is retired as a no-op and flagged
   always_comb begin
      case (op)
         ceob_pkg::op_nop,
         ceob_pkg::op_sub_two,
         ceob_pkg::op_irq_dis,
         ceob_pkg::op_irq_en,
         ceob_pkg::op_add_one,
         ceob_pkg::op_add_two,
         ceob_pkg::op_compl,
         ceob_pkg::op_br_carry,
         ceob_pkg::op_br_zero,
         ceob_pkg::op_br_sge: nxt_bad = 1'b0;
         default:             nxt_bad = run;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         done_ff  <= 1'b0;
         taken_ff <= 1'b0;
         bad_ff   <= 1'b0;
      end else if (ce) begin
         done_ff  <= exec_valid;
         taken_ff <= exec_valid & is_branch & br_taken;
         bad_ff   <= nxt_bad;
      end
   end

   // ----------------------------------------------------------------
   // interrupt window
   // ----------------------------------------------------------------
   // the shadow arms on an enable and stays until one more instruction
   // has retired, so a request already waiting cannot cut in between
   always_comb begin
      nxt_shadow = shadow_ff;
      if (run) begin
         nxt_shadow = (op == ceob_pkg::op_irq_en);
      end
   end

   // acceptance looks at the registered enable: a disable stops requests
   // only from the boundary after it, which software has to allow for
   assign irq_ok = irq_pending & flag_ff[`CEOB_FLAG_GIE] & ~shadow_ff
                 & ~flag_load;

   // instruction in flight wins; the interrupt is taken at the next gap
   assign nxt_irq_take = irq_ok & ~exec_valid;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         shadow_ff   <= 1'b0;
         irq_take_ff <= 1'b0;
      end else if (ce) begin
         shadow_ff   <= nxt_shadow;
         irq_take_ff <= nxt_irq_take;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign exec_done         = done_ff;
   assign dst_wr            = wr_ff;
   assign dst_result        = result_ff;
   assign branch_taken      = taken_ff;
   assign bad_op            = bad_ff;
   assign flag_word         = flag_ff;
   assign pc                = pc_ff;
   assign global_irq_enable = flag_ff[`CEOB_FLAG_GIE];
   assign osc_halt_bit      = flag_ff[`CEOB_FLAG_OSC_HALT_BIT];
   assign core_halt_bit     = flag_ff[`CEOB_FLAG_CORE_HALT_BIT];
   assign irq_take          = irq_take_ff;

endmodule

// ===== bench/ceob_exec_properties.sv
// bound checker for the emulated-op and branch executor
`timescale 1ns/10ps
module ceob_exec_properties (
   // clock and reset
   input wire logic                clk,
   input wire logic                nrst,
   // requests
   input wire logic                ce,
   input wire logic                exec_valid,
   input wire ceob_pkg::ceob_req_t exec_req,
   input wire logic                pc_load,
   input wire logic                flag_load,
   // results
   input wire logic                exec_done,
   input wire logic                branch_taken,
   input wire logic [15:0]         flag_word,
   input wire logic [19:0]         pc,
   input wire logic                irq_take
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   logic               go;
   ceob_pkg::ceob_op_t op;
   logic [19:0]        tgt;

   // a load in the same cycle overrides flags or pc, so it is excluded
   assign go  = ce && exec_valid;
   assign op  = exec_req.op;
   assign tgt = pc + 20'h00002 +
                {{9{exec_req.offset[9]}}, exec_req.offset, 1'b0};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   property p_done;
      go |=> exec_done;
   endproperty
   a_done: assert property (p_done) else $error("no done pulse");

   property p_irq_dis;
      go && op == ceob_pkg::op_irq_dis && !flag_load
         |=> flag_word == ($past(flag_word) & 16'hfff7);
   endproperty
   a_irq_dis: assert property (p_irq_dis) else $error("disable bad");

   property p_irq_en;
      go && op == ceob_pkg::op_irq_en && !flag_load
         |=> flag_word == ($past(flag_word) | 16'h0008);
   endproperty
   a_irq_en: assert property (p_irq_en) else $error("enable bad");

   property p_shadow;
      go && op == ceob_pkg::op_irq_en |=> !irq_take [*2];
   endproperty
   a_shadow: assert property (p_shadow) else $error("irq in shadow");

   property p_br_flags;
      go && op inside {ceob_pkg::op_br_carry, ceob_pkg::op_br_zero,
                       ceob_pkg::op_br_sge} && !flag_load
         |=> $stable(flag_word);
   endproperty
   a_br_flags: assert property (p_br_flags) else $error("flags moved");

   property p_mode_kept;
      go && op inside {ceob_pkg::op_sub_two, ceob_pkg::op_add_one,
                       ceob_pkg::op_add_two, ceob_pkg::op_compl}
         && !flag_load |=> flag_word[5:3] == $past(flag_word[5:3]);
   endproperty
   a_mode_kept: assert property (p_mode_kept) else $error("mode bits");

   property p_br_zero;
      go && op == ceob_pkg::op_br_zero && flag_word[1] && !pc_load
         |=> branch_taken && pc == $past(tgt);
   endproperty
   a_br_zero: assert property (p_br_zero) else $error("zero branch");

   property p_br_carry;
      go && op == ceob_pkg::op_br_carry && !flag_word[0] && !pc_load
         |=> !branch_taken && pc == $past(pc) + 20'h00002;
   endproperty
   a_br_carry: assert property (p_br_carry) else $error("carry branch");

   property p_br_sge;
      go && op == ceob_pkg::op_br_sge
         |=> branch_taken == !($past(flag_word[2]) ^ $past(flag_word[8]));
   endproperty
   a_br_sge: assert property (p_br_sge) else $error("sge branch");
endmodule

bind ceob_exec ceob_exec_properties u_props (
   .clk(clk), .nrst(nrst), .ce(ce), .exec_valid(exec_valid),
   .exec_req(exec_req), .pc_load(pc_load), .flag_load(flag_load),
   .exec_done(exec_done), .branch_taken(branch_taken),
   .flag_word(flag_word), .pc(pc), .irq_take(irq_take)
);

// ===== bench/ceob_exec_bench.sv
// self-checking bench for the emulated-op and branch executor
`timescale 1ns/10ps
module ceob_exec_bench;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic               clk = 1'b0, nrst = 1'b0, ce = 1'b0;
   logic               exec_valid = 1'b0, pc_load = 1'b0;
   logic               flag_load = 1'b0, irq_pending = 1'b0;
   ceob_pkg::ceob_req_t exec_req = '0;
   logic [19:0]        pc_load_val = 20'h00000;
   logic [15:0]        flag_load_val = 16'h0000;
   logic               exec_done, dst_wr, branch_taken, bad_op, irq_take;
   logic               global_irq_enable, osc_halt_bit, core_halt_bit;
   logic [15:0]        dst_result, flag_word;
   logic [19:0]        pc;
   int                 n_fail = 0, n_compared = 0;
   logic [15:0]        cn [15] = '{16'h0000, 16'h0001, 16'h0002, 16'h007e,
      16'h007f, 16'h0080, 16'h0081, 16'h00fe, 16'h00ff, 16'h7ffe,
      16'h7fff, 16'h8000, 16'h8001, 16'hfffe, 16'hffff};
   ceob_pkg::ceob_op_t ar [4] = '{ceob_pkg::op_sub_two,
      ceob_pkg::op_add_one, ceob_pkg::op_add_two, ceob_pkg::op_compl};
   ceob_pkg::ceob_op_t br [3] = '{ceob_pkg::op_br_carry,
      ceob_pkg::op_br_zero, ceob_pkg::op_br_sge};

   // 25 MHz clock
   always #20 clk = ~clk;

   ceob_exec dut (
      .clk(clk), .nrst(nrst), .ce(ce), .exec_valid(exec_valid),
      .exec_req(exec_req), .pc_load(pc_load), .pc_load_val(pc_load_val),
      .flag_load(flag_load), .flag_load_val(flag_load_val),
      .irq_pending(irq_pending), .exec_done(exec_done), .dst_wr(dst_wr),
      .dst_result(dst_result), .branch_taken(branch_taken),
      .bad_op(bad_op), .flag_word(flag_word), .pc(pc),
      .global_irq_enable(global_irq_enable), .osc_halt_bit(osc_halt_bit),
      .core_halt_bit(core_halt_bit), .irq_take(irq_take)
   );

   // ---------------------------------------------------------------
   // tasks and expectation functions
   // ---------------------------------------------------------------
   task results;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task check(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // pc and flag_word loaded together; both win over any execution
   task load(input logic [19:0] p, input logic [15:0] f);
      @(posedge clk);
      pc_load <= 1'b1;
      flag_load <= 1'b1;
      pc_load_val <= p;
      flag_load_val <= f;
      @(posedge clk);
      pc_load <= 1'b0;
      flag_load <= 1'b0;
   endtask

   // one instruction; results are looked at 1 ns after the edge that takes it
   task issue(input ceob_pkg::ceob_op_t op, input logic bm,
              input logic [15:0] d, input logic [9:0] o);
      @(posedge clk);
      exec_valid <= 1'b1;
      exec_req <= '{op, bm, d, o};
      @(posedge clk);
      exec_valid <= 1'b0;
      #1;
   endtask

   // core add or xor with the implied constant source: {r, n, z, c, v}
   function automatic logic [19:0] ref_alu(ceob_pkg::ceob_op_t op,
                                           logic bm, logic [15:0] d);
      logic [15:0] a, b, r, m;
      logic [16:0] s;
      logic        n, z, c, v, x;
      int          k;
      k = bm ? 7 : 15;
      m = bm ? 16'h00ff : 16'hffff;
      a = d & m;
      x = (op == ceob_pkg::op_compl);
      b = (op == ceob_pkg::op_add_one) ? 16'h0001 :
          (op == ceob_pkg::op_add_two) ? 16'h0002 : 16'hfffe & m;
      s = {1'b0, a} + {1'b0, b};
      r = x ? a ^ m : s[15:0] & m;
      n = r[k];
      z = (r == 16'h0000);
      c = x ? !z : (bm ? s[8] : s[16]);
      v = x ? a[k] : (a[k] == b[k] && r[k] != a[k]);
      return {r, n, z, c, v};
   endfunction

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      logic [15:0]        d, f;
      logic [19:0]        e, p;
      logic [9:0]         o;
      logic               t, bm;
      ceob_pkg::ceob_op_t op;
      d = $urandom(46);
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      ce <= 1'b1;
      @(posedge clk);
      #1;
      check("flag_word", flag_word, 16'h0000);
      check("pc", pc, 20'h00000);
      // corner destinations for every op and width, then random ones
      for (int i = 0; i < 320; i++) begin
         op = ar[i % 4];
         bm = (i / 4) % 2;
         d = (i < 120) ? cn[(i / 8) % 15] : 16'($urandom);
         f = $urandom;
         p = $urandom;
         load(p, f);
         issue(op, bm, d, 10'($urandom));
         e = ref_alu(op, bm, d);
         check("dst_result", dst_result, e[19:4]);
         check("flag_word", flag_word, (f & 16'hfef8) |
               {7'h00, e[0], 5'h00, e[3:1]});
         check("pc", pc, p + 20'h00002);
         check("dst_wr", dst_wr, 1'b1);
      end
      // interrupt enable and disable on random flag words
      for (int i = 0; i < 40; i++) begin
         op = i[0] ? ceob_pkg::op_irq_en : ceob_pkg::op_irq_dis;
         f = $urandom;
         load(20'($urandom), f);
         issue(op, 1'b0, 16'($urandom), 10'h000);
         e[15:0] = i[0] ? f | `CEOB_IRQ_MASK : f & ~`CEOB_IRQ_MASK;
         check("flag_word", flag_word, e[15:0]);
         check("global_irq_enable", global_irq_enable, i[0]);
      end
      // branches with offset extremes first, then random offsets
      for (int i = 0; i < 150; i++) begin
         op = br[i % 3];
         f = $urandom;
         p = $urandom;
         o = (i < 9) ? ((i < 3) ? 10'h1ff : (i < 6) ? 10'h200 : 10'h3ff)
                     : 10'($urandom);
         t = (op == ceob_pkg::op_br_carry) ? f[0] :
             (op == ceob_pkg::op_br_zero) ? f[1] : !(f[2] ^ f[8]);
         load(p, f);
         issue(op, 1'b0, 16'($urandom), o);
         e = p + 20'h00002 + (t ? {{9{o[9]}}, o, 1'b0} : 20'h00000);
         check("pc", pc, e);
         check("branch_taken", branch_taken, t);
         check("flag_word", flag_word, f);
      end
      // pending request: held off while disabled and in the shadow
      load(20'h00100, 16'h0000);
      irq_pending <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check("irq_take", irq_take, 1'b0);
      issue(ceob_pkg::op_irq_en, 1'b0, 16'h0000, 10'h000);
      check("irq_take", irq_take, 1'b0);
      @(posedge clk);
      #1;
      check("irq_take", irq_take, 1'b0);
      issue(ceob_pkg::op_nop, 1'b0, 16'h0000, 10'h000);
      check("irq_take", irq_take, 1'b0);
      @(posedge clk);
      #1;
      check("irq_take", irq_take, 1'b1);
      check("global_irq_enable", global_irq_enable, 1'b0);
      @(posedge clk);
      irq_pending <= 1'b0;
      // unknown code retires as a no-op; disable padded by a no-op
      load(20'h00300, 16'h0038);
      issue(ceob_pkg::ceob_op_t'(4'ha), 1'b0, 16'h0000, 10'h000);
      check("bad_op", bad_op, 1'b1);
      check("pc", pc, 20'h00302);
      check("osc_halt_bit", osc_halt_bit, 1'b1);
      check("core_halt_bit", core_halt_bit, 1'b1);
      issue(ceob_pkg::op_irq_dis, 1'b0, 16'h0000, 10'h000);
      issue(ceob_pkg::op_nop, 1'b0, 16'h0000, 10'h000);
      check("global_irq_enable", global_irq_enable, 1'b0);
      check("flag_word", flag_word, 16'h0030);
      // clock enable low freezes execution
      load(20'h00200, 16'h0000);
      @(posedge clk);
      ce <= 1'b0;
      exec_valid <= 1'b1;
      exec_req <= '{ceob_pkg::op_add_one, 1'b0, 16'h0000, 10'h000};
      repeat (2) @(posedge clk);
      #1;
      check("exec_done", exec_done, 1'b0);
      check("pc", pc, 20'h00200);
      @(posedge clk);
      ce <= 1'b1;
      exec_valid <= 1'b0;
      repeat (2) @(posedge clk);
      results();
   end
endmodule
